// ==== src/uchbp_top.sv ====
// Parallel processor port with command/data port pairs and two DMA slave channels
// Functional notes
// R1: The port has a 16-bit data bus and decodes only two address inputs, giving four port locations.
// R2: With chip select low, codes 00/01/10/11 select host data, host command, device data and device command ports.
// R3: While the read strobe is low the addressed data port is driven onto the bus for the processor to take.
// R4: While the write strobe is low the processor drives a command or data word which the port captures.
// R5: The processor first writes a register index to a command port and then transfers data on the matching data port.
// R6: An index is eight bits in the low byte of the bus word and the processor drives the upper byte as zeros.
// R7: A 32-bit register takes two data phases after its index, low half first and high half second.
// R8: Host index 27h is a read-only identity register returning a 16-bit code on the host data port.
// R9: There are two DMA channels with their own request and acknowledge, channel 1 for host and channel 2 for device.
// R10: The processor system DMA controller is the master of all DMA transfers and the port is only a slave.
// R11: An asserted external end-of-transfer input ends the ongoing DMA transfer.
// R12: Setting the host DMA setup register, read at 21h and written at A1h, enables the internal transfer counter.
// R13: When the enabled counter equals the transfer count (read 22h, written A2h) an internal end-of-transfer ends DMA.
// R14: The low address input selects the command port when high and the data port when low.
// R15: The high address input routes the access to the device side when high and the host side when low.
// R16: The last written index is held per controller so data phases target it until a new index is written.
// R17: After end-of-transfer the channel's DMA request stays low until a new transfer is set up.
`timescale 1ns/1ps
`include "uchbp_defines.svh"

module uchbp_top
  import uchbp_pkg::*;
#(
  parameter logic [15:0] CHIP_IDENTITY = 16'h5a3c
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_kind_select,
  input wire logic controller_select,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  output logic host_dma_request,
  input wire logic host_dma_ack_n,
  output logic device_dma_request,
  input wire logic device_dma_ack_n,
  input wire logic end_of_transfer_in
);

  // ==========================================
  // Reset release
  // Two stages so every register leaves reset on the same edge
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================
  // Helpers
  // Command code that writes the register read at idx
  function automatic logic [7:0] write_of(input logic [7:0] idx);
    write_of = idx | `UCHBP_WRITE_FLAG;
  endfunction

  // Byte count after one more acknowledged word
  function automatic logic [31:0] next_count(input logic [31:0] cnt);
    next_count = cnt + `UCHBP_BYTES_PER_WORD;
  endfunction

  // Close a channel: the request stays low until setup is written again
  function automatic uchbp_chan_t end_transfer(input uchbp_chan_t c);
    end_transfer = c;
    end_transfer.req = 1'b0;
    end_transfer.setup[`UCHBP_BIT_DMA_ENABLE] = 1'b0;
  endfunction

  // Only the device count register is 32 bits wide, for its read and write codes alike
  function automatic logic is_wide(input logic ctl, input logic [7:0] idx);
    is_wide = (ctl == `UCHBP_CTL_DEV) && (write_of(idx) == write_of(`UCHBP_IDX_DEV_COUNT));
  endfunction

  function automatic logic [7:0] setup_idx(input logic ctl);
    setup_idx = (ctl == `UCHBP_CTL_DEV) ? `UCHBP_IDX_DEV_DMA_SETUP : `UCHBP_IDX_HOST_DMA_SETUP;
  endfunction

  function automatic logic [7:0] count_idx(input logic ctl);
    count_idx = (ctl == `UCHBP_CTL_DEV) ? `UCHBP_IDX_DEV_COUNT : `UCHBP_IDX_HOST_COUNT;
  endfunction

  function automatic logic [15:0] read_word(input logic ctl, input uchbp_ptr_t p, input uchbp_chan_t c);
    read_word = `UCHBP_IDLE_WORD;
    if (p.index == setup_idx(ctl)) begin
      read_word = c.setup;
    end else if (p.index == count_idx(ctl)) begin
      read_word = p.phase ? c.count[31:16] : c.count[15:0]; // see R7
    end else if (ctl == `UCHBP_CTL_HOST && p.index == `UCHBP_IDX_HOST_ID) begin
      read_word = CHIP_IDENTITY; // see R8
    end
  endfunction

  // ==========================================
  // State
  uchbp_state_t state_reg;
  uchbp_state_t state_next;

  logic rd_start;
  logic wr_start;
  logic ctl;
  logic [1:0] ack_n;
  logic dma_active;
  // Access decode shared by the read path and the register writes
  logic reg_access;
  logic data_read;
  logic setup_hit;
  logic count_hit;

  always_comb begin
    state_next = state_reg;
    state_next.rd_n_q = rd_n;
    state_next.wr_n_q = wr_n;
    ack_n = {device_dma_ack_n, host_dma_ack_n};
    // DMA strobes carry no chip select, so an acknowledge alone claims the bus
    dma_active = !host_dma_ack_n || !device_dma_ack_n;
    rd_start = !rd_n && state_reg.rd_n_q;
    wr_start = !wr_n && state_reg.wr_n_q;
    ctl = controller_select; // see R15
    reg_access = !cs_n && !dma_active; // see R1, R2
    data_read = !rd_n && reg_access && !port_kind_select; // see R14
    setup_hit = state_reg.ptr[ctl].index == write_of(setup_idx(ctl));
    count_hit = state_reg.ptr[ctl].index == write_of(count_idx(ctl));

    // Bus output: drive while a data port or an acknowledged DMA read is active
    state_next.oe_n = 1'b1;
    state_next.dout = `UCHBP_IDLE_WORD;
    if (data_read) begin
      state_next.oe_n = 1'b0; // see R3, R14
      // Taken once per strobe: a held strobe must not show the next half of a 32-bit register
      if (rd_start) begin
        state_next.dout = read_word(ctl, state_reg.ptr[ctl], state_reg.chan[ctl]); // see R7
      end else begin
        state_next.dout = state_reg.dout;
      end
    end else if (!rd_n && dma_active) begin
      state_next.oe_n = 1'b0; // see R10
    end

    // Register port accesses, not taken while a DMA acknowledge owns the bus
    if (reg_access) begin // see R1, R2
      if (wr_start && port_kind_select) begin
        // A new index restarts a 32-bit register at its low half
        state_next.ptr[ctl].index = data_in[7:0]; // see R5, R6, R16
        state_next.ptr[ctl].phase = 1'b0;
      end else if (wr_start) begin
        if (setup_hit) begin // see R4
          state_next.chan[ctl].setup = data_in; // see R12
          state_next.chan[ctl].counter = `UCHBP_COUNT_RESET;
          state_next.chan[ctl].req = data_in[`UCHBP_BIT_DMA_ENABLE];
        end else if (count_hit) begin
          if (state_reg.ptr[ctl].phase) begin
            state_next.chan[ctl].count[31:16] = data_in; // see R7
          end else if (is_wide(ctl, count_idx(ctl))) begin
            state_next.chan[ctl].count[15:0] = data_in;
          end else begin
            // A 16-bit count write clears the upper half
            state_next.chan[ctl].count = {16'h0000, data_in};
          end
        end
        if (is_wide(ctl, state_reg.ptr[ctl].index)) begin
          state_next.ptr[ctl].phase = !state_reg.ptr[ctl].phase; // see R7
        end
      end else if (rd_start && !port_kind_select) begin
        if (is_wide(ctl, state_reg.ptr[ctl].index)) begin
          state_next.ptr[ctl].phase = !state_reg.ptr[ctl].phase; // see R7
        end
      end
    end

    // DMA channels: one word per acknowledged strobe
    for (int i = 0; i < 2; i++) begin
      if (state_reg.chan[i].req && !ack_n[i]) begin // see R9
        if (rd_start || wr_start) begin
          state_next.chan[i].counter = next_count(state_reg.chan[i].counter);
          // Counter select picks the internal end; the external end is honoured whenever acknowledged
          if (state_reg.chan[i].setup[`UCHBP_BIT_COUNTER_SELECT] &&
              next_count(state_reg.chan[i].counter) == state_reg.chan[i].count) begin
            state_next.chan[i] = end_transfer(state_next.chan[i]); // see R13, R17
          end
        end
        if (end_of_transfer_in) begin
          state_next.chan[i] = end_transfer(state_next.chan[i]); // see R11, R17
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      for (int i = 0; i < 2; i++) begin
        state_reg.chan[i].setup <= `UCHBP_SETUP_RESET;
        state_reg.chan[i].count <= `UCHBP_COUNT_RESET;
        state_reg.chan[i].counter <= `UCHBP_COUNT_RESET;
        state_reg.chan[i].req <= 1'b0;
        state_reg.ptr[i].index <= `UCHBP_IDX_RESET;
        state_reg.ptr[i].phase <= 1'b0;
      end
      state_reg.rd_n_q <= 1'b1;
      state_reg.wr_n_q <= 1'b1;
      state_reg.dout <= `UCHBP_IDLE_WORD;
      state_reg.oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Outputs
  // Every output is a field of the state register
  assign data_out = state_reg.dout;
  assign data_oe_n = state_reg.oe_n;
  assign host_dma_request = state_reg.chan[0].req;
  assign device_dma_request = state_reg.chan[1].req;

endmodule

// ==== include/uchbp_defines.svh ====
// Constants for the combined host/device bus port
`ifndef UCHBP_DEFINES_SVH
`define UCHBP_DEFINES_SVH
`define UCHBP_CTL_HOST 1'b0
`define UCHBP_CTL_DEV 1'b1
`define UCHBP_WRITE_FLAG 8'h80
`define UCHBP_IDX_HOST_DMA_SETUP 8'h21
`define UCHBP_IDX_HOST_COUNT 8'h22
`define UCHBP_IDX_HOST_ID 8'h27
`define UCHBP_IDX_DEV_DMA_SETUP 8'h71
`define UCHBP_IDX_DEV_COUNT 8'h73
`define UCHBP_SETUP_RESET 16'h0000
`define UCHBP_COUNT_RESET 32'h0000_0000
`define UCHBP_BIT_DMA_ENABLE 0
`define UCHBP_BIT_COUNTER_SELECT 1
`define UCHBP_BYTES_PER_WORD 32'h0000_0002
`define UCHBP_IDX_RESET 8'h00
`define UCHBP_IDLE_WORD 16'h0000
`endif

// ==== include/uchbp_pkg.sv ====
// Types for the combined host/device bus port
package uchbp_pkg;
  typedef struct packed {
    logic [15:0] setup;
    logic [31:0] count;
    logic [31:0] counter;
    logic req;
  } uchbp_chan_t;

  typedef struct packed {
    logic [7:0] index;
    logic phase;
  } uchbp_ptr_t;

  typedef struct packed {
    uchbp_chan_t [1:0] chan;
    uchbp_ptr_t [1:0] ptr;
    logic rd_n_q;
    logic wr_n_q;
    logic [15:0] dout;
    logic oe_n;
  } uchbp_state_t;
endpackage

// ==== tb/uchbp_monitor.sv ====
// Checker for the bus port decode and the DMA request handshakes
`timescale 1ns/1ps
module uchbp_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_kind_select,
  input wire logic controller_select,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe_n,
  input wire logic host_dma_request,
  input wire logic host_dma_ack_n,
  input wire logic device_dma_request,
  input wire logic device_dma_ack_n,
  input wire logic end_of_transfer_in
);
  // ==========
  // Port and request checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic idle = host_dma_ack_n && device_dma_ack_n;
  property p_rd_drive; !cs_n && !rd_n && !port_kind_select |=> !data_oe_n; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("data read not driven");
  property p_cmd_quiet; !cs_n && !rd_n && port_kind_select && idle |=> data_oe_n; endproperty
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("command port driven");
  property p_release; rd_n |=> data_oe_n; endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_idle_zero; data_oe_n |-> data_out == 16'h0000; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle data not zero");
  property p_deselect; cs_n && idle |=> data_oe_n; endproperty
  a_deselect: assert property (p_deselect) else $error("driven while deselected");
  property p_dev_eot; device_dma_request && !device_dma_ack_n && end_of_transfer_in |-> ##[1:2] !device_dma_request;
  endproperty
  a_dev_eot: assert property (p_dev_eot) else $error("request kept after end");
  property p_dev_hold; device_dma_request && device_dma_ack_n |=> device_dma_request; endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("request dropped early");
  property p_host_hold; host_dma_request && host_dma_ack_n |=> host_dma_request; endproperty
  a_host_hold: assert property (p_host_hold) else $error("host request dropped early");
  property p_req_cause; $rose(host_dma_request) || $rose(device_dma_request)
    |-> !$past(wr_n) || !$past(wr_n, 2) || !$past(wr_n, 3); endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without setup");
endmodule
bind uchbp_top uchbp_monitor u_monitor (
  .clock(clock),
  .rstn(rstn),
  .cs_n(cs_n),
  .rd_n(rd_n),
  .wr_n(wr_n),
  .port_kind_select(port_kind_select),
  .controller_select(controller_select),
  .data_in(data_in),
  .data_out(data_out),
  .data_oe_n(data_oe_n),
  .host_dma_request(host_dma_request),
  .host_dma_ack_n(host_dma_ack_n),
  .device_dma_request(device_dma_request),
  .device_dma_ack_n(device_dma_ack_n),
  .end_of_transfer_in(end_of_transfer_in)
);

// ==== tb/uchbp_dma_master.sv ====
// DMA master model for one channel of the bus port
`timescale 1ns/1ps
module uchbp_dma_master (
  input wire logic clock,
  input wire logic rstn,
  input wire logic req,
  input wire logic go,
  output logic ack_n,
  output logic rd_n
);
  // ==========
  // Grant follows request; one read strobe every second cycle while granted
  always_ff @(negedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_n <= 1'b1;
      rd_n <= 1'b1;
    end else begin
      ack_n <= !(req && go);
      rd_n <= !(req && go && !ack_n && rd_n);
    end
  end
endmodule

// ==== tb/usb_combo_host_bus_port_bench.sv ====
// Self-checking bench for the combined host/device bus port
`timescale 1ns/1ps
module usb_combo_host_bus_port_bench;
  localparam logic [15:0] ID = 16'h1c4e; // Arbitrary identity value
  logic clock = 0, rstn = 0, cs_n = 1, bench_rd_n = 1, wr_n = 1, port_kind_select = 0, controller_select = 0;
  logic end_of_transfer_in = 0, go_h = 0, go_d = 0;
  logic [15:0] data_in = 16'h0000, data_out;
  logic data_oe_n, host_dma_request, device_dma_request;
  wire logic host_dma_ack_n, device_dma_ack_n, h_rd_n, d_rd_n;
  wire logic rd_n = bench_rd_n & h_rd_n & d_rd_n;
  int err_total = 0, check_count = 0, strobes = 0;
  uchbp_top #(.CHIP_IDENTITY(ID)) u_dut (
    .clock(clock),
    .rstn(rstn),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .port_kind_select(port_kind_select),
    .controller_select(controller_select),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .host_dma_request(host_dma_request),
    .host_dma_ack_n(host_dma_ack_n),
    .device_dma_request(device_dma_request),
    .device_dma_ack_n(device_dma_ack_n),
    .end_of_transfer_in(end_of_transfer_in)
  );
  uchbp_dma_master u_hm (.clock, .rstn, .req(host_dma_request), .go(go_h), .ack_n(host_dma_ack_n), .rd_n(h_rd_n));
  uchbp_dma_master u_dm (.clock, .rstn, .req(device_dma_request), .go(go_d), .ack_n(device_dma_ack_n), .rd_n(d_rd_n));
  initial forever #2 clock = ~clock;
  always @(negedge h_rd_n) if (host_dma_ack_n === 1'b0) strobes++;
  // ==========
  // Bus cycles and scenarios
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at time %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [15:0] d);
    @(negedge clock) {cs_n, wr_n, controller_select, port_kind_select, data_in} = {2'b00, a, d};
    @(negedge clock) {cs_n, wr_n} = 2'b11;
    @(negedge clock);
  endtask
  task automatic rd(logic [1:0] a, logic [15:0] exp);
    @(negedge clock) {cs_n, bench_rd_n, controller_select, port_kind_select} = {2'b00, a};
    repeat (2) @(negedge clock);
    check(data_out, exp);
    check({15'h0, data_oe_n}, {15'h0, a[0]});
    @(negedge clock) {cs_n, bench_rd_n} = 2'b11;
    @(negedge clock);
  endtask
  task automatic t_ident;
    wr(2'b01, 16'h0027);
    rd(2'b00, ID);
    rd(2'b01, 16'h0000);
    wr(2'b01, 16'h00a7);
    wr(2'b00, 16'hffff);
    wr(2'b01, 16'h0027);
    rd(2'b00, ID);
    wr(2'b01, 16'h0030);
    rd(2'b00, 16'h0000);
    $display("Identity test done");
  endtask
  task automatic t_regs;
    wr(2'b01, 16'h00a2);
    wr(2'b00, 16'h1234);
    wr(2'b01, 16'h0022);
    wr(2'b11, 16'h00f3);
    wr(2'b10, 16'h5678);
    wr(2'b10, 16'h9abc);
    wr(2'b11, 16'h0073);
    rd(2'b10, 16'h5678);
    rd(2'b10, 16'h9abc);
    rd(2'b00, 16'h1234);
    $display("Register test done");
  endtask
  task automatic t_host_dma;
    wr(2'b01, 16'h00a2);
    wr(2'b00, 16'h0006);
    wr(2'b01, 16'h00a1);
    wr(2'b00, 16'h0003);
    repeat (2) @(negedge clock);
    check({15'h0, host_dma_request}, 16'h0001);
    strobes = 0;
    go_h <= 1;
    repeat (60) if (host_dma_request) @(negedge clock);
    go_h <= 0;
    check({15'h0, host_dma_request}, 16'h0000);
    check(16'(strobes), 16'h0003);
    repeat (2) @(negedge clock);
    wr(2'b01, 16'h0021);
    rd(2'b00, 16'h0002);
    $display("Host DMA test done");
  endtask
  task automatic t_dev_dma;
    wr(2'b11, 16'h00f1);
    wr(2'b10, 16'h0001);
    @(negedge clock) end_of_transfer_in = 1;
    repeat (3) @(negedge clock);
    end_of_transfer_in = 0;
    check({15'h0, device_dma_request}, 16'h0001);
    go_d <= 1;
    repeat (4) @(negedge clock);
    end_of_transfer_in = 1;
    repeat (6) if (device_dma_request) @(negedge clock);
    end_of_transfer_in = 0;
    go_d <= 0;
    check({15'h0, device_dma_request}, 16'h0000);
    $display("Device DMA test done");
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock);
    rstn = 1;
    repeat (4) @(negedge clock);
    t_ident;
    t_regs;
    t_host_dma;
    t_dev_dma;
    complete_run;
  end
  initial begin
    #20000;
    err_total++;
    complete_run;
  end
endmodule
